// ---- include/pfc_pkg.sv ----
package pfc_pkg;
   // Geometry
   localparam int NQ = 8;
   localparam int QW = 16;
   localparam int WORD_W = 32;
   localparam int MACA_W = 48;
   localparam int HI_W = 16;
   localparam int CTRL_W = 4;
   localparam int CYC_W = 8;
   localparam int BEAT_W = 64;
   localparam int BEATS = 8;
   localparam int FRM_W = BEAT_W * BEATS;
   localparam int PAUSE_HDR_W = 2 * MACA_W + 3 * HI_W;
   localparam int PFC_HDR_W = 2 * MACA_W + 3 * HI_W + NQ * QW;
   localparam int PAUSE_PAD = FRM_W - PAUSE_HDR_W;
   localparam int PFC_PAD = FRM_W - PFC_HDR_W;

   // Pause quantum: 512 bit times on a 25 Gb/s link, rounded up to clock cycles
   localparam int LINK_MBPS = 25000;
   localparam int QUANTUM_BITS = 512;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int QUANTUM_PS = QUANTUM_BITS * 1000000 / LINK_MBPS;
   localparam int QUANTUM_CYC_I = (QUANTUM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [CYC_W-1:0] QUANTUM_CYC = CYC_W'((QUANTUM_CYC_I < 1) ? 1 : QUANTUM_CYC_I);
   localparam logic [CYC_W-1:0] CYC_ONE = 8'h01;

   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ENABLE = 8'h04;
   localparam logic [7:0] A_REQ = 8'h08;
   localparam logic [7:0] A_DA_LO = 8'h0c;
   localparam logic [7:0] A_DA_HI = 8'h10;
   localparam logic [7:0] A_SA_LO = 8'h14;
   localparam logic [7:0] A_SA_HI = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1c;
   localparam logic [7:0] A_QUANTA = 8'h20;
   localparam logic [7:0] A_HOLD = 8'h40;
   localparam logic [7:0] A_HOLD_END = 8'h60;
   localparam int QIDX_LSB = 2;
   localparam int QIDX_MSB = 4;

   // Control fields
   localparam int CTRL_PFC = 0;
   localparam int CTRL_REQ2 = 1;
   localparam int CTRL_SRC_SIG = 2;
   localparam int CTRL_BOUNDARY = 3;
   localparam int ST_BUSY = 16;
   localparam int ST_HALT = 17;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;
   localparam logic [NQ-1:0] EN_RST = 8'hff;
   localparam logic [QW-1:0] QUANTA_RST = 16'hffff;
   localparam logic [QW-1:0] HOLD_RST = 16'h00ff;
   localparam logic [MACA_W-1:0] DA_RST = 48'h0180c2000001;
   localparam logic [MACA_W-1:0] SA_RST = 48'h000000000000;

   // MAC control frame fields
   localparam logic [HI_W-1:0] ETH_MAC_CTRL = 16'h8808;
   localparam logic [HI_W-1:0] OP_PAUSE = 16'h0001;
   localparam logic [HI_W-1:0] OP_PFC = 16'h0101;
   localparam logic [2:0] EMPTY_LAST = 3'h4;
   localparam logic [2:0] BEAT_LAST = 3'h7;
   localparam logic [2:0] BEAT_ETH = 3'h1;

   typedef enum logic {PFC_IDLE, PFC_SEND} pfc_state_t;
endpackage

// ---- verilog/pfc_flow_ctrl.sv ----
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
// What this block does
// - Requests come from registers or input signals
// - 1-bit or 2-bit request format, 1-bit after reset
// - XOFF frame carries the programmed quanta
// - Repeat frame after per-queue hold gap while XOFF
// - At least one pause quantum between frames
// - No frames once no queue requests
// - XOFF to XON sends zero quanta
// - Exactly one XON frame, never repeated
// - Standard mode sends Pause frames, same behaviour
// - Received Pause halts client in standard mode only, now or at boundary
// - Resume needs a zero Pause, which clears the remaining time
// - Pause ignored when flow control disabled
// - CTRL_SRC_SIG selects register or signal source, in 1-bit and 2-bit modes
module pfc_flow_ctrl
   import pfc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [NQ-1:0] xon_xoff_request_in0,
   input wire logic [NQ-1:0] xon_xoff_request_in1,
   input wire logic fc_ready,
   output logic fc_valid,
   output logic fc_sop,
   output logic fc_eop,
   output logic [2:0] fc_empty,
   output logic [BEAT_W-1:0] fc_data,
   input wire logic rx_pause_valid,
   input wire logic [QW-1:0] rx_pause_quanta,
   input wire logic tx_client_in_frame,
   output logic tx_client_halt
);

   logic [CTRL_W-1:0] ctrl_r;
   logic [NQ-1:0] en_r;
   logic [2*NQ-1:0] req_r;
   logic [MACA_W-1:0] da_r;
   logic [MACA_W-1:0] sa_r;
   logic [QW-1:0] quanta_r [NQ];
   logic [QW-1:0] hold_r [NQ];
   logic [QW-1:0] hold_cnt_r [NQ];
   logic [NQ-1:0] xoff_r;
   logic [NQ-1:0] prev_r;
   logic [NQ-1:0] pend_r;
   logic [NQ*QW-1:0] times;
   logic [FRM_W-1:0] frm;
   logic [FRM_W-1:0] frm_r;
   pfc_state_t state_r;
   logic [2:0] beat_r;
   logic [CYC_W-1:0] gap_r;
   logic [CYC_W-1:0] qcnt_r;
   logic qtick;
   logic take;
   logic pfc_mode;
   logic req2_mode;
   logic sig_src;
   logic boundary_mode;
   logic halt_req_r;
   logic zero_seen_r;
   logic [QW-1:0] ptimer_r;
   logic accept;

   assign pfc_mode = ctrl_r[CTRL_PFC];
   assign req2_mode = ctrl_r[CTRL_REQ2];
   assign sig_src = ctrl_r[CTRL_SRC_SIG];
   assign boundary_mode = ctrl_r[CTRL_BOUNDARY];

   // Register writes
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= CTRL_RST;
         en_r <= EN_RST;
         req_r <= '0;
         da_r <= DA_RST;
         sa_r <= SA_RST;
         for (int i = 0; i < NQ; i++) begin
            quanta_r[i] <= QUANTA_RST;
            hold_r[i] <= HOLD_RST;
         end
      end else if (reg_wr) begin
         if (reg_addr == A_CTRL) begin
            ctrl_r <= reg_wdata[CTRL_W-1:0];
         end else if (reg_addr == A_ENABLE) begin
            en_r <= reg_wdata[NQ-1:0];
         end else if (reg_addr == A_REQ) begin
            req_r <= reg_wdata[2*NQ-1:0];
         end else if (reg_addr == A_DA_LO) begin
            da_r[WORD_W-1:0] <= reg_wdata;
         end else if (reg_addr == A_DA_HI) begin
            da_r[MACA_W-1:WORD_W] <= reg_wdata[HI_W-1:0];
         end else if (reg_addr == A_SA_LO) begin
            sa_r[WORD_W-1:0] <= reg_wdata;
         end else if (reg_addr == A_SA_HI) begin
            sa_r[MACA_W-1:WORD_W] <= reg_wdata[HI_W-1:0];
         end else if (reg_addr >= A_QUANTA && reg_addr < A_HOLD) begin
            quanta_r[reg_addr[QIDX_MSB:QIDX_LSB]] <= reg_wdata[QW-1:0];
         end else if (reg_addr >= A_HOLD && reg_addr < A_HOLD_END) begin
            hold_r[reg_addr[QIDX_MSB:QIDX_LSB]] <= reg_wdata[QW-1:0];
         end
      end
   end

   // Register reads, data valid the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         if (reg_addr == A_CTRL) begin
            reg_rdata <= {{(WORD_W-CTRL_W){1'b0}}, ctrl_r};
         end else if (reg_addr == A_ENABLE) begin
            reg_rdata <= {{(WORD_W-NQ){1'b0}}, en_r};
         end else if (reg_addr == A_REQ) begin
            reg_rdata <= {{(WORD_W-2*NQ){1'b0}}, req_r};
         end else if (reg_addr == A_DA_LO) begin
            reg_rdata <= da_r[WORD_W-1:0];
         end else if (reg_addr == A_DA_HI) begin
            reg_rdata <= {{(WORD_W-HI_W){1'b0}}, da_r[MACA_W-1:WORD_W]};
         end else if (reg_addr == A_SA_LO) begin
            reg_rdata <= sa_r[WORD_W-1:0];
         end else if (reg_addr == A_SA_HI) begin
            reg_rdata <= {{(WORD_W-HI_W){1'b0}}, sa_r[MACA_W-1:WORD_W]};
         end else if (reg_addr == A_STATUS) begin
            reg_rdata <= {{(WORD_W-ST_HALT-1){1'b0}}, tx_client_halt, (state_r == PFC_SEND), pend_r, xoff_r};
         end else if (reg_addr >= A_QUANTA && reg_addr < A_HOLD) begin
            reg_rdata <= {{(WORD_W-QW){1'b0}}, quanta_r[reg_addr[QIDX_MSB:QIDX_LSB]]};
         end else if (reg_addr >= A_HOLD && reg_addr < A_HOLD_END) begin
            reg_rdata <= {{(WORD_W-QW){1'b0}}, hold_r[reg_addr[QIDX_MSB:QIDX_LSB]]};
         end else begin
            reg_rdata <= '0;
         end
      end else begin
         reg_rdata <= '0;
      end
   end

   // Pause quantum time base
   assign qtick = (qcnt_r == '0);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         qcnt_r <= '0;
      end else if (qtick) begin
         qcnt_r <= QUANTUM_CYC - CYC_ONE;
      end else begin
         qcnt_r <= qcnt_r - CYC_ONE;
      end
   end

   assign take = (state_r == PFC_IDLE) && (pend_r != '0) && (gap_r == '0);

   for (genvar q = 0; q < NQ; q++) begin : g_q
      logic en_q;
      logic xoff_in;
      logic xon_in;
      logic lvl_nxt;
      logic set_q;
      // Standard mode runs on queue 0 alone
      assign en_q = en_r[q] && (pfc_mode || q == 0);
      assign xoff_in = sig_src ? xon_xoff_request_in0[q] : req_r[q];
      assign xon_in = sig_src ? xon_xoff_request_in1[q] : req_r[NQ+q];
      always_comb begin
         if (!en_q) begin
            lvl_nxt = 1'b0;
         end else if (!req2_mode) begin
            lvl_nxt = xoff_in;
         end else if (xoff_in && !xon_in) begin
            lvl_nxt = 1'b1;
         end else if (xon_in && !xoff_in) begin
            lvl_nxt = 1'b0;
         end else begin
            lvl_nxt = xoff_r[q];
         end
      end
      // Edge of the level raises one frame; a held XOFF re-arms by the hold counter
      assign set_q = en_q && ((xoff_r[q] != prev_r[q]) || (xoff_r[q] && hold_cnt_r[q] == '0 && !pend_r[q]));
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            xoff_r[q] <= 1'b0;
            prev_r[q] <= 1'b0;
            pend_r[q] <= 1'b0;
            hold_cnt_r[q] <= '0;
         end else begin
            xoff_r[q] <= lvl_nxt;
            prev_r[q] <= xoff_r[q];
            // A new request wins over the take of the previous one
            pend_r[q] <= en_q && ((pend_r[q] && !take) || set_q);
            if (take && pend_r[q]) begin
               hold_cnt_r[q] <= (hold_r[q] == '0) ? QW'(1) : hold_r[q];
            end else if (qtick && hold_cnt_r[q] != '0) begin
               hold_cnt_r[q] <= hold_cnt_r[q] - QW'(1);
            end
         end
      end
      assign times[(NQ-1-q)*QW +: QW] = xoff_r[q] ? quanta_r[q] : '0;
   end

   // Frame image: DA, SA, type, opcode, body, zero pad to 60 bytes
   always_comb begin
      if (pfc_mode) begin
         frm = {da_r, sa_r, ETH_MAC_CTRL, OP_PFC, {(HI_W-NQ){1'b0}}, pend_r, times, {PFC_PAD{1'b0}}};
      end else begin
         frm = {da_r, sa_r, ETH_MAC_CTRL, OP_PAUSE, times[NQ*QW-1 -: QW], {PAUSE_PAD{1'b0}}};
      end
   end

   // Frame sender and inter-frame gap
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= PFC_IDLE;
         beat_r <= '0;
         gap_r <= '0;
         frm_r <= '0;
         fc_valid <= 1'b0;
         fc_sop <= 1'b0;
         fc_eop <= 1'b0;
         fc_empty <= '0;
         fc_data <= '0;
      end else begin
         case (state_r)
            PFC_IDLE: begin
               if (gap_r != '0) begin
                  gap_r <= gap_r - CYC_ONE;
               end
               if (take) begin
                  frm_r <= frm;
                  state_r <= PFC_SEND;
                  beat_r <= '0;
                  fc_valid <= 1'b1;
                  fc_sop <= 1'b1;
                  fc_data <= frm[FRM_W-1 -: BEAT_W];
               end
            end
            PFC_SEND: begin
               if (fc_ready) begin
                  if (beat_r == BEAT_LAST) begin
                     state_r <= PFC_IDLE;
                     gap_r <= QUANTUM_CYC;
                     fc_valid <= 1'b0;
                     fc_eop <= 1'b0;
                     fc_empty <= '0;
                  end else begin
                     beat_r <= beat_r + 3'h1;
                     fc_sop <= 1'b0;
                     fc_eop <= (beat_r == BEAT_LAST - 3'h1);
                     fc_empty <= (beat_r == BEAT_LAST - 3'h1) ? EMPTY_LAST : 3'h0;
                     fc_data <= frm_r[FRM_W-1-BEAT_W*(int'(beat_r)+1) -: BEAT_W];
                  end
               end
            end
            default: state_r <= PFC_IDLE;
         endcase
      end
   end

   // Received Pause handling in standard mode
   assign accept = rx_pause_valid && !pfc_mode && en_r[0];
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         halt_req_r <= 1'b0;
         zero_seen_r <= 1'b0;
         ptimer_r <= '0;
      end else begin
         if (accept && rx_pause_quanta == '0) begin
            zero_seen_r <= 1'b1;
            ptimer_r <= '0;
         end else if (accept) begin
            zero_seen_r <= 1'b0;
            ptimer_r <= rx_pause_quanta;
            halt_req_r <= 1'b1;
         end else if (qtick && ptimer_r != '0) begin
            ptimer_r <= ptimer_r - QW'(1);
         end
         if (!accept && halt_req_r && ptimer_r == '0 && zero_seen_r) begin
            halt_req_r <= 1'b0;
         end
      end
   end

   // Boundary mode waits for the client to be between frames before halting
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_client_halt <= 1'b0;
      end else begin
         tx_client_halt <= halt_req_r && (tx_client_halt || !boundary_mode || !tx_client_in_frame);
      end
   end

   req1_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!req2_mode && sig_src && en_r[0] && xon_xoff_request_in0[0]) |=> xoff_r[0])
      else $error("one-bit request not followed");
   mode_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(rst_b) |-> !req2_mode)
      else $error("request mode not one-bit after reset");
   repeat_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (en_r[0] && pfc_mode && xoff_r[0] && hold_cnt_r[0] == '0) |=> (pend_r[0] || hold_cnt_r[0] != '0 || !en_r[0]))
      else $error("held queue not re-requested");
   gap_min_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (fc_valid && fc_eop && fc_ready) |=> !fc_valid [*3])
      else $error("frames closer than one quantum");
   no_spurious_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!xoff_r[0] && !$changed(xoff_r[0]) && !pend_r[0]) |=> !pend_r[0])
      else $error("frame requested with no request");
   xon_pend_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($fell(xoff_r[0]) && $past(en_r[0]) && en_r[0] && pfc_mode && $stable(en_r[0])) |=> pend_r[0])
      else $error("xon transition raised no frame");
   ethtype_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (fc_valid && beat_r == BEAT_ETH) |-> fc_data[WORD_W-1:HI_W] == ETH_MAC_CTRL)
      else $error("wrong ethertype");
   halt_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (accept && rx_pause_quanta != '0 && !boundary_mode) |=> ##1 tx_client_halt)
      else $error("client not halted");
   resume_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(halt_req_r) |-> ($past(zero_seen_r) && $past(ptimer_r) == '0))
      else $error("resumed without both conditions");
   ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (rx_pause_valid && !en_r[0] && !halt_req_r) |=> !halt_req_r)
      else $error("pause honoured while disabled");
   two_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (req2_mode && sig_src && xon_xoff_request_in1[0] && !xon_xoff_request_in0[0]) |=> !xoff_r[0])
      else $error("two-bit xon from signals ignored");
endmodule

// ---- test/pfc_link_partner.sv ----
`timescale 1ns/10ps
module pfc_link_partner
   import pfc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic fc_valid,
   input wire logic fc_sop,
   input wire logic fc_eop,
   input wire logic [2:0] fc_empty,
   input wire logic [BEAT_W-1:0] fc_data,
   output logic fc_ready,
   input wire logic pause_go,
   input wire logic [QW-1:0] pause_q,
   output logic rx_pause_valid = 1'b0,
   output logic [QW-1:0] rx_pause_quanta = '0,
   output logic frm_done = 1'b0,
   output logic [3:0] frm_beats = '0,
   output logic [2:0] frm_empty = '0,
   output logic [3*BEAT_W-1:0] frm_head = '0,
   output logic [15:0] frm_gap = '0,
   output logic paused = 1'b0
);
   logic [7:0] tick_r = '0;
   logic [23:0] hold_r = '0;
   logic [15:0] idle_r = '0;
   logic [15:0] t;
   // Slow mode refuses two beats out of four
   assign fc_ready = !slow || tick_r[1];
   assign t = (frm_head[79:64] == OP_PFC) ? frm_head[47:32] : frm_head[63:48];
   always @(posedge clk_sys) begin
      tick_r <= tick_r + 8'h01;
      frm_done <= 1'b0;
      rx_pause_valid <= pause_go;
      // Quanta lines show the inverse when no frame is decoded
      rx_pause_quanta <= pause_go ? pause_q : ~rx_pause_quanta;
      // Gap runs from the last accepted end beat; a refused first beat does not restart it
      idle_r <= (fc_valid && fc_ready && fc_eop) ? 16'h0000 : (fc_valid ? idle_r : idle_r + 16'h0001);
      if (hold_r != 24'h0) begin
         hold_r <= hold_r - 24'h1;
      end else begin
         paused <= 1'b0;
      end
      if (fc_valid && fc_ready) begin
         frm_beats <= fc_sop ? 4'h1 : frm_beats + 4'h1;
         if (fc_sop) begin
            frm_gap <= idle_r;
         end
         if (fc_sop || frm_beats < 4'h3) begin
            frm_head <= {(fc_sop ? 128'h0 : frm_head[127:0]), fc_data};
         end
         if (fc_eop) begin
            frm_done <= 1'b1;
            frm_empty <= fc_empty;
            paused <= t != 16'h0000;
            hold_r <= 24'(t) * 24'(QUANTUM_CYC);
         end
      end
   end
endmodule

// ---- test/test_pfc_flow_ctrl.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_pfc_flow_ctrl
   import pfc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic b0 = 1'b0;
   logic b1 = 1'b0;
   logic slow = 1'b0;
   logic pause_go = 1'b0;
   logic in_frame = 1'b0;
   logic [QW-1:0] pause_q = '0;
   logic [31:0] rnd = 32'h5eb3;
   logic [NQ-1:0] in0, in1;
   logic [31:0] reg_rdata, rx;
   logic fc_ready, fc_valid, fc_sop, fc_eop, halt, rx_pv, frm_done, paused;
   logic [2:0] fc_empty, frm_empty;
   logic [BEAT_W-1:0] fc_data;
   logic [QW-1:0] rx_pq;
   logic [3:0] frm_beats;
   logic [3*BEAT_W-1:0] frm_head;
   logic [15:0] frm_gap;
   logic [79:0] fq[$];
   logic [31:0] rdq[$];
   logic [79:0] e;
   logic [47:0] sa_r = '0;
   logic rd_d = 1'b0;
   int fail_count = 0;
   int n_compared = 0;
   int nfrm = 0;
   int cyc = 0;
   assign in0 = {rnd[7:1], b0};
   assign in1 = {rnd[15:9], b1};
   always #5 clk_sys = ~clk_sys;
   pfc_flow_ctrl uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xon_xoff_request_in0(in0),
      .xon_xoff_request_in1(in1), .fc_ready(fc_ready), .fc_valid(fc_valid), .fc_sop(fc_sop), .fc_eop(fc_eop),
      .fc_empty(fc_empty), .fc_data(fc_data), .rx_pause_valid(rx_pv), .rx_pause_quanta(rx_pq),
      .tx_client_in_frame(in_frame), .tx_client_halt(halt));
   pfc_link_partner partner (.clk_sys(clk_sys), .slow(slow), .fc_valid(fc_valid), .fc_sop(fc_sop),
      .fc_eop(fc_eop), .fc_empty(fc_empty), .fc_data(fc_data), .fc_ready(fc_ready), .pause_go(pause_go),
      .pause_q(pause_q), .rx_pause_valid(rx_pv), .rx_pause_quanta(rx_pq), .frm_done(frm_done),
      .frm_beats(frm_beats), .frm_empty(frm_empty), .frm_head(frm_head), .frm_gap(frm_gap), .paused(paused));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [63:0] w2(input logic pfc, input logic [15:0] q);
      return pfc ? {16'h0001, q, 32'h0} : {q, 48'h0};
   endfunction
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      rdq.push_back(d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic pause(input logic [15:0] q);
      pause_go <= 1'b1;
      pause_q <= q;
      @(posedge clk_sys);
      pause_go <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wait_frame();
      int c0;
      c0 = nfrm;
      for (int t = 0; t < 400 && nfrm == c0; t++) @(posedge clk_sys);
      `CHK(nfrm != c0, 1'b1)
   endtask
   // Raise or drop the queue 0 request through the source and format chosen in c
   task automatic req(input logic [3:0] c, input logic off);
      if (!c[2]) begin
         wr(A_REQ, c[1] ? (off ? 32'h1 : 32'h100) : {31'h0, off});
      end else if (!c[1]) begin
         b0 <= off;
      end else begin
         if (off) b0 <= 1'b1;
         else b1 <= 1'b1;
         @(posedge clk_sys);
         b0 <= 1'b0;
         b1 <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task automatic run_mode(input logic [3:0] c);
      logic [15:0] q;
      logic [15:0] op;
      int c0;
      q = rnd[31:16] | 16'h0001;
      op = c[0] ? OP_PFC : OP_PAUSE;
      slow <= c[2];
      wr(A_CTRL, {28'h0, c});
      wr(A_QUANTA, {16'h0, q});
      wr(A_HOLD, 32'h10);
      rd(A_CTRL, {28'h0, c});
      rd(A_QUANTA, {16'h0, q});
      fq.push_back({op, w2(c[0], q)});
      req(c, 1'b1);
      wait_frame();
      fq.push_back({op, w2(c[0], q)});
      wait_frame();
      `CHK(frm_gap >= 16'd30, 1'b1)
      fq.push_back({op, w2(c[0], 16'h0)});
      req(c, 1'b0);
      wait_frame();
      c0 = nfrm;
      repeat (150) @(posedge clk_sys);
      `CHK(nfrm, c0)
   endtask
   always @(posedge clk_sys) begin
      rnd <= xs(rnd);
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   always @(posedge clk_sys) begin
      if (rd_d && rdq.size() > 0) begin
         rx = rdq.pop_front();
         `CHK(reg_rdata, rx)
      end
      rd_d <= reg_rd;
      if (frm_done) begin
         nfrm++;
         e = (fq.size() > 0) ? fq.pop_front() : '1;
         `CHK(frm_head[79:0], e)
         `CHK(frm_head[191:80], {DA_RST, sa_r, ETH_MAC_CTRL})
         `CHK({frm_beats, frm_empty}, {4'h8, EMPTY_LAST})
         `CHK(frm_gap >= 16'(QUANTUM_CYC), 1'b1)
         `CHK(paused, (e[79:64] == OP_PFC) ? (e[47:32] != 16'h0) : (e[63:48] != 16'h0))
      end
   end
   initial begin
      logic [7:0] ra [8];
      logic [31:0] rv [8];
      logic [3:0] md [6];
      ra = '{A_CTRL, A_ENABLE, A_QUANTA, A_HOLD, A_DA_LO, A_DA_HI, A_SA_HI, 8'h64};
      rv = '{{28'h0, CTRL_RST}, {24'h0, EN_RST}, {16'h0, QUANTA_RST}, {16'h0, HOLD_RST}, DA_RST[31:0],
         {16'h0, DA_RST[47:32]}, {16'h0, SA_RST[47:32]}, 32'h0};
      md = '{4'h1, 4'h5, 4'h7, 4'h3, 4'h0, 4'h6};
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      wr(8'h64, 32'hffff_ffff);
      for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
      sa_r = {rnd[15:0], rnd};
      wr(A_SA_LO, sa_r[31:0]);
      wr(A_SA_HI, {16'h0, sa_r[47:32]});
      rd(A_SA_HI, {16'h0, sa_r[47:32]});
      wr(A_ENABLE, 32'h1);
      foreach (md[i]) run_mode(md[i]);
      wr(A_CTRL, 32'h0);
      pause(16'h2);
      repeat (3) @(posedge clk_sys);
      `CHK(halt, 1'b1)
      repeat (12) @(posedge clk_sys);
      `CHK(halt, 1'b1)
      pause(16'h0);
      repeat (3) @(posedge clk_sys);
      `CHK(halt, 1'b0)
      wr(A_CTRL, 32'h8);
      in_frame <= 1'b1;
      pause(16'h5);
      repeat (3) @(posedge clk_sys);
      `CHK(halt, 1'b0)
      in_frame <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK(halt, 1'b1)
      pause(16'h0);
      wr(A_ENABLE, 32'h0);
      pause(16'h3);
      repeat (3) @(posedge clk_sys);
      `CHK(halt, 1'b0)
      `CHK(fq.size() + rdq.size(), 0)
      complete_run();
   end
endmodule
